// >>> src/text_display_map.vh
`ifndef TEXT_DISPLAY_MAP_VH
`define TEXT_DISPLAY_MAP_VH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define ADDR_COILS      8'h00
`define ADDR_MODE       8'h04
`define ADDR_KEYS       8'h08
`define ADDR_RETAIN     8'h0C
`define ADDR_STATUS     8'h10
`define ADDR_SCALE_CFG  8'h14
`define ADDR_SCALE_IN   8'h18
`define ADDR_SCALE_OUT  8'h1C
`define ADDR_SETPOINT   8'h20

// ****************************************************************
// Field positions.
// ****************************************************************
`define MODE_RUN_BIT    0
`define MODE_STATUS_BIT 1
`define MODE_POWER_BIT  2
`define KEY_OK_BIT      0
`define KEY_DELETE_BIT  1
`define KEY_ALT_BIT     2
`define KEY_ESC_BIT     3
`define SETPOINT_LINE_BIT 16

// ****************************************************************
// Reset values and sizes.
// ****************************************************************
`define COILS_RESET     16'h0000
`define MODE_RESET      3'h0
`define RETAIN_RESET    8'h00
`define SCALE_CFG_RESET 2'h0
`define SLOT_COUNT      16
`define RETAIN_SLOTS    8
`define TEXT_LINES      4
`define LINE_CHARS      12

// ****************************************************************
// Scaling ranges and timing.
// ****************************************************************
`define SCALE_UNSIGNED  2'h0
`define SCALE_PM999     2'h1
`define SCALE_PM99      2'h2
`define SCALE_MAX_U     32'sd9999
`define SCALE_MAX_S     32'sd999
`define SCALE_MAX_T     32'sd99
`define ROTATE_TIME_S   4
`define CLK_HZ          100000000

`endif

// >>> src/text_display_sequencer.v
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "text_display_map.vh"

module text_display_sequencer #(
	parameter [31:0] ROTATE_CYCLES = `ROTATE_TIME_S * `CLK_HZ
) (
	// Clock and reset.
	input  wire        clk_sys,
	input  wire        reset,
	// APB slave.
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// Display selection.
	output reg  [4:0]  displaySlot,
	output reg         displayValid,
	output reg         editActive
);

	// ****************************************************************
	// Sequencer states.
	// ****************************************************************
	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_ALARM  = 3'h1;
	localparam [2:0] ST_ROTATE = 3'h2;
	localparam [2:0] ST_EDIT   = 3'h3;
	localparam [2:0] ST_MENU   = 3'h4;

	reg  [15:0] coils_q;
	reg  [2:0]  mode_q;
	reg  [7:0]  retain_q;
	reg  [1:0]  scaleCfg_q;
	reg  [15:0] scaleIn_q;
	reg  [15:0] scaleOut_q;
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	reg  [3:0]  slot_q;
	reg  [3:0]  slot_d;
	reg  [31:0] timer_q;
	reg         run_q;
	reg         power_q;
	reg  [15:0] setpointMem [0:31];
	reg  [31:0] scaled;
	reg  [31:0] product;

	wire        wrEn      = psel & penable & pwrite;
	wire        setupRead = psel & ~penable & ~pwrite;
	wire        runOn     = mode_q[`MODE_RUN_BIT];
	wire        statusOn  = mode_q[`MODE_STATUS_BIT];
	wire        powerOn   = mode_q[`MODE_POWER_BIT];
	wire        keyWr     = wrEn && (paddr == `ADDR_KEYS);
	wire        okKey     = keyWr & pwdata[`KEY_OK_BIT];
	wire        delKey    = keyWr & pwdata[`KEY_DELETE_BIT];
	wire        altKey    = keyWr & pwdata[`KEY_ALT_BIT];
	wire        escKey    = keyWr & pwdata[`KEY_ESC_BIT];
	wire        showOk    = runOn & statusOn & powerOn;
	wire        alarmOn   = coils_q[0] & showOk;
	wire [15:0] rotMask   = {coils_q[15:1], 1'b0};
	wire        anyRot    = |rotMask;
	wire        timerDone = (timer_q >= ROTATE_CYCLES - 32'h00000001);
	wire [15:0] keepMask  = {8'h00, retain_q};

	// ****************************************************************
	// Helper functions.
	// ****************************************************************

	// Next active slot after cur, ascending, wrapping past 15 to slot 1 (never slot 0); cur itself if alone.
	function [3:0] nextSlot;
		input [15:0] mask;
		input [3:0]  cur;
		integer      k;
		reg   [4:0]  idx;
		begin
			nextSlot = cur;
			for (k = 15; k >= 1; k = k - 1) begin
				idx = {1'b0, cur} + k[4:0];
				if (idx > 5'h0F) begin
					idx = idx - 5'h0F;
				end
				if (mask[idx[3:0]]) begin
					nextSlot = idx[3:0];
				end
			end
		end
	endfunction

	// Address decode for the error answer; the read mux decodes paddr in its own case.
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `ADDR_COILS) || (a == `ADDR_MODE) || (a == `ADDR_KEYS) ||
				(a == `ADDR_RETAIN) || (a == `ADDR_STATUS) || (a == `ADDR_SCALE_CFG) ||
				(a == `ADDR_SCALE_IN) || (a == `ADDR_SCALE_OUT) ||
				(a == `ADDR_SETPOINT);
		end
	endfunction

	// ****************************************************************
	// Bus answer.
	// ****************************************************************

	// Zero wait states: read data is captured during setup, so it is a flop.
	assign pready = 1'b1;

	// Read mux; there is deliberately no parameter-menu register per slot.
	always @(posedge clk_sys) begin
		if (reset) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			pslverr <= ~mapped(paddr);
			prdata  <= 32'h00000000;
			if (setupRead) begin
				case (paddr)
					`ADDR_COILS:     prdata <= {16'h0000, coils_q};
					`ADDR_MODE:      prdata <= {29'h00000000, mode_q};
					`ADDR_RETAIN:    prdata <= {24'h000000, retain_q};
					`ADDR_STATUS:    prdata <= {24'h000000, state_q, displayValid,
						slot_q};
					`ADDR_SCALE_CFG: prdata <= {30'h00000000, scaleCfg_q};
					`ADDR_SCALE_IN:  prdata <= {16'h0000, scaleIn_q};
					`ADDR_SCALE_OUT: prdata <= {16'h0000, scaleOut_q};
					`ADDR_SETPOINT:  prdata <= {setpointMem[{slot_q, 1'b1}],
						setpointMem[{slot_q, 1'b0}]};
					default:         prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ****************************************************************
	// Coils, mode and retention.
	// ****************************************************************

	// Coils only change while the program runs; stop and power loss clear the
	// contacts that are not retentive, so retentive ones resume on restart.
	always @(posedge clk_sys) begin
		if (reset) begin
			coils_q  <= `COILS_RESET;
			mode_q   <= `MODE_RESET;
			retain_q <= `RETAIN_RESET;
			run_q    <= 1'b0;
			power_q  <= 1'b0;
		end else begin
			run_q   <= runOn;
			power_q <= powerOn;
			if (wrEn && (paddr == `ADDR_MODE)) begin
				mode_q <= pwdata[2:0];
			end
			if (wrEn && (paddr == `ADDR_RETAIN)) begin
				retain_q <= pwdata[`RETAIN_SLOTS-1:0];
			end
			if ((run_q & ~runOn) | (power_q & ~powerOn)) begin
				coils_q <= coils_q & keepMask;
			end else if (wrEn && (paddr == `ADDR_COILS) && runOn && powerOn) begin
				coils_q <= pwdata[`SLOT_COUNT-1:0];
			end
		end
	end

	// ****************************************************************
	// Display sequencer.
	// ****************************************************************

	// Next state; alarm outranks everything except an open menu or an edit.
	always @* begin
		state_d = state_q;
		slot_d  = slot_q;
		case (state_q)
			ST_IDLE: begin
				if (alarmOn) begin
					state_d = ST_ALARM;
				end else if (showOk & anyRot) begin
					state_d = ST_ROTATE;
					slot_d  = nextSlot(rotMask, 4'h0);
				end
			end
			ST_ALARM: begin
				if (~alarmOn) begin
					state_d = ST_IDLE;
				end else if (okKey | (delKey & altKey)) begin
					state_d = ST_MENU;
				end else if (altKey) begin
					state_d = ST_EDIT;
				end
			end
			ST_ROTATE: begin
				if (alarmOn) begin
					state_d = ST_ALARM;
				end else if (~showOk | ~anyRot) begin
					state_d = ST_IDLE;
				end else if (okKey | (delKey & altKey)) begin
					state_d = ST_MENU;
				end else if (altKey) begin
					state_d = ST_EDIT;
				end else if (~rotMask[slot_q] | timerDone) begin
					slot_d = nextSlot(rotMask, slot_q);
				end
			end
			ST_EDIT: begin
				// The text is frozen while a value is entered.
				if (~showOk | escKey) begin
					state_d = ST_IDLE;
				end
			end
			ST_MENU: begin
				if (~showOk | escKey) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (state_d == ST_ALARM) begin
			slot_d = 4'h0;
		end
	end

	// State, slot and 4 s dwell timer; timer restarts at every slot change.
	always @(posedge clk_sys) begin
		if (reset) begin
			state_q <= ST_IDLE;
			slot_q  <= 4'h0;
			timer_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			slot_q  <= slot_d;
			if ((state_d != ST_ROTATE) || (slot_d != slot_q) || (state_q != ST_ROTATE)) begin
				timer_q <= 32'h00000000;
			end else begin
				timer_q <= timer_q + 32'h00000001;
			end
		end
	end

	// Registered display outputs, slot numbered 1 to 16.
	always @(posedge clk_sys) begin
		if (reset) begin
			displaySlot  <= 5'h00;
			displayValid <= 1'b0;
			editActive   <= 1'b0;
		end else begin
			displayValid <= (state_d == ST_ALARM) || (state_d == ST_ROTATE) ||
				(state_d == ST_EDIT);
			displaySlot  <= (state_d == ST_IDLE || state_d == ST_MENU) ? 5'h00 :
				({1'b0, slot_d} + 5'h01);
			editActive   <= (state_d == ST_EDIT);
		end
	end

	// ****************************************************************
	// Setpoint fields and analog scaling.
	// ****************************************************************

	// Only the field on line two or three of the shown text may change.
	always @(posedge clk_sys) begin
		if (wrEn && (paddr == `ADDR_SETPOINT) && (state_q == ST_EDIT)) begin
			setpointMem[{slot_q, pwdata[`SETPOINT_LINE_BIT]}] <= pwdata[15:0];
		end
	end

	// Input is signed hundredths of a volt, -1000 to +1000; the multiply
	// and shift trade a little accuracy for a divider-free datapath.
	always @* begin
		product = $signed({{16{scaleIn_q[15]}}, scaleIn_q});
		scaled  = 32'h00000000;
		case (scaleCfg_q)
			`SCALE_UNSIGNED: begin
				scaled = $signed(product * 32'sd10239) >>> 10;
				if ($signed(scaled) < 0) begin
					scaled = 32'h00000000;
				end else if ($signed(scaled) > `SCALE_MAX_U) begin
					scaled = `SCALE_MAX_U;
				end
			end
			`SCALE_PM999: begin
				scaled = $signed(product * 32'sd1023) >>> 10;
				if ($signed(scaled) > `SCALE_MAX_S) begin
					scaled = `SCALE_MAX_S;
				end else if ($signed(scaled) < -`SCALE_MAX_S) begin
					scaled = -`SCALE_MAX_S;
				end
			end
			`SCALE_PM99: begin
				scaled = $signed(product * 32'sd102) >>> 10;
				if ($signed(scaled) > `SCALE_MAX_T) begin
					scaled = `SCALE_MAX_T;
				end else if ($signed(scaled) < -`SCALE_MAX_T) begin
					scaled = -`SCALE_MAX_T;
				end
			end
			default: begin
				scaled = 32'h00000000;
			end
		endcase
	end

	// Scaling registers.
	always @(posedge clk_sys) begin
		if (reset) begin
			scaleCfg_q <= `SCALE_CFG_RESET;
			scaleIn_q  <= 16'h0000;
			scaleOut_q <= 16'h0000;
		end else begin
			if (wrEn && (paddr == `ADDR_SCALE_CFG)) begin
				scaleCfg_q <= pwdata[1:0];
			end
			if (wrEn && (paddr == `ADDR_SCALE_IN)) begin
				scaleIn_q <= pwdata[15:0];
			end
			scaleOut_q <= scaled[15:0];
		end
	end

endmodule

`default_nettype wire

// >>> bench/text_display_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Display selection checks.
// ****************************************
module text_display_sequencer_checker #(
	parameter [31:0] ROTATE_CYCLES = 32'h0000_0014
) (
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        reset,
	// Register bus.
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Display selection.
	input wire logic [4:0]  displaySlot,
	input wire logic        displayValid,
	input wire logic        editActive
);
	// A write seen at the edge that completes it; output may follow one or two edges on.
	wire wrAcc = psel && penable && pwrite && pready;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	property p_shown_slot;
		displayValid |-> displaySlot >= 5'h01 && displaySlot <= 5'h10;
	endproperty
	a_shown_slot: assert property (p_shown_slot) else $error("slot out of range");
	property p_blank_slot;
		!displayValid |-> displaySlot == 5'h00;
	endproperty
	a_blank_slot: assert property (p_blank_slot) else $error("slot while blank");
	property p_edit_shown;
		editActive |-> displayValid;
	endproperty
	a_edit_shown: assert property (p_edit_shown) else $error("edit without text");
	// The edited text must stay put, or the operator edits the wrong value.
	property p_edit_frozen;
		editActive && $past(editActive) |-> $stable(displaySlot);
	endproperty
	a_edit_frozen: assert property (p_edit_frozen) else $error("slot moved in edit");
	property p_status_off;
		wrAcc && paddr == 8'h04 && !pwdata[1] |-> ##[1:2] !displayValid;
	endproperty
	a_status_off: assert property (p_status_off) else $error("shown, status off");
	property p_stop_blank;
		wrAcc && paddr == 8'h04 && !(pwdata[0] && pwdata[2]) |-> ##[1:2] !displayValid;
	endproperty
	a_stop_blank: assert property (p_stop_blank) else $error("shown in stop");
	property p_menu_blank;
		wrAcc && paddr == 8'h08 && !editActive && !pwdata[3]
			&& (pwdata[0] || (pwdata[1] && pwdata[2])) |-> ##[1:2] !displayValid;
	endproperty
	a_menu_blank: assert property (p_menu_blank) else $error("shown in menu");
	property p_alarm_take;
		wrAcc && paddr == 8'h00 && pwdata[0] && displayValid && !editActive
			|-> ##[1:2] displaySlot == 5'h01;
	endproperty
	a_alarm_take: assert property (p_alarm_take) else $error("alarm not shown");
	property p_alarm_drop;
		wrAcc && paddr == 8'h00 && !pwdata[0] && displaySlot == 5'h01 && !editActive
			|-> ##[1:2] displaySlot != 5'h01;
	endproperty
	a_alarm_drop: assert property (p_alarm_drop) else $error("alarm stays");
endmodule
`default_nettype wire

// >>> bench/circuit_program_model.sv
`timescale 1ns/1ps
`default_nettype none
// The circuit program and the operator panel, acting as bus master.
module circuit_program_model (
	// Clock and bus answer.
	input  wire logic        clk_sys,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	// Bus request.
	output var  logic [7:0]  paddr,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [31:0] pwdata
);
	// Bus idle from time zero.
	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
	end
	// One transfer, entered just after an edge; one idle edge follows so calls never collide.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> bench/test_text_display_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_text_display_sequencer;
	localparam int ROT = 20;
	logic        clk_sys;
	logic        reset;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [4:0]  displaySlot;
	logic        displayValid;
	logic        editActive;
	logic [31:0] rd;
	logic        er;
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	// A short rotation period keeps the run brief.
	text_display_sequencer #(.ROTATE_CYCLES(ROT)) u_text_display_sequencer (
		.clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.displaySlot(displaySlot), .displayValid(displayValid), .editActive(editActive));
	circuit_program_model u_circuit_program_model (
		.clk_sys(clk_sys), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
	// Clock.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// A hang is cut short well past the few hundred cycles the run needs.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_circuit_program_model.xfer(a, 1'b1, d, rd, er);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		u_circuit_program_model.xfer(a, 1'b0, 32'h0000_0000, rd, er);
		chk(rd, e);
	endtask
	task automatic waitSlot(input logic [4:0] e);
		int n;
		n = 0;
		while (displaySlot !== e && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		chk({27'h0, displaySlot}, {27'h0, e});
	endtask
	task automatic t_reset();
		rdchk(8'h10, 32'h0000_0000);
		chk({31'h0, displayValid}, 32'h0000_0000);
	endtask
	task automatic t_gate();
		wr(8'h00, 32'h0000_0014);
		rdchk(8'h00, 32'h0000_0000);
		wr(8'h04, 32'h0000_0007);
		wr(8'h00, 32'h0000_0014);
		rdchk(8'h00, 32'h0000_0014);
		waitSlot(5'h03);
	endtask
	task automatic t_rotate();
		int n;
		waitSlot(5'h05);
		n = 0;
		while (displaySlot !== 5'h03 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n, ROT);
	endtask
	task automatic t_alarm();
		wr(8'h00, 32'h0000_0015);
		waitSlot(5'h01);
		rdchk(8'h10, 32'h0000_0030);
		repeat (2 * ROT) @(posedge clk_sys);
		chk({27'h0, displaySlot}, 32'h0000_0001);
		wr(8'h00, 32'h0000_0014);
		waitSlot(5'h03);
	endtask
	// Both menu key combinations; escape brings the lowest slot back.
	task automatic t_menu();
		for (int i = 0; i < 2; i++) begin
			wr(8'h08, i ? 32'h0000_0006 : 32'h0000_0001);
			waitSlot(5'h00);
			wr(8'h08, 32'h0000_0008);
			waitSlot(5'h03);
		end
	endtask
	task automatic t_edit();
		wr(8'h08, 32'h0000_0004);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, editActive}, 32'h0000_0001);
		wr(8'h20, 32'h0000_0012);
		wr(8'h20, 32'h0001_0034);
		rdchk(8'h20, 32'h0034_0012);
		wr(8'h08, 32'h0000_0008);
		waitSlot(5'h03);
	endtask
	// Status off, stop, then power loss; only the retentive slot three survives.
	task automatic t_retain();
		wr(8'h0C, 32'h0000_FF04);
		rdchk(8'h0C, 32'h0000_0004);
		wr(8'h04, 32'h0000_0005);
		waitSlot(5'h00);
		wr(8'h04, 32'h0000_0006);
		waitSlot(5'h00);
		rdchk(8'h00, 32'h0000_0004);
		wr(8'h04, 32'h0000_0003);
		waitSlot(5'h00);
		wr(8'h04, 32'h0000_0007);
		rdchk(8'h00, 32'h0000_0004);
		waitSlot(5'h03);
	endtask
	// Full-scale inputs must land on range ends: both unsigned ends, -999 and +99.
	task automatic t_scale();
		wr(8'h14, 32'h0000_0000);
		wr(8'h18, 32'h0000_03E8);
		rdchk(8'h1C, 32'h0000_270F);
		chk({31'h0, er}, 32'h0000_0000);
		wr(8'h18, 32'h0000_FC18);
		rdchk(8'h1C, 32'h0000_0000);
		wr(8'h14, 32'h0000_0001);
		rdchk(8'h1C, 32'h0000_FC19);
		wr(8'h14, 32'h0000_0002);
		wr(8'h18, 32'h0000_03E8);
		rdchk(8'h1C, 32'h0000_0063);
	endtask
	task automatic t_unmapped();
		rdchk(8'h40, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
	endtask
	// Main sequence.
	initial begin
		reset = 1'b1;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_gate();
		t_rotate();
		t_alarm();
		t_menu();
		t_edit();
		t_retain();
		t_scale();
		t_unmapped();
		end_of_test();
	end
endmodule
bind text_display_sequencer text_display_sequencer_checker #(.ROTATE_CYCLES(ROTATE_CYCLES)) u_chk (
	.clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.displaySlot(displaySlot), .displayValid(displayValid), .editActive(editActive));
`default_nettype wire
